// file: hdl/msag_cfg.svh
/*
 constant file of the sync analyzer/generator: register offsets, field positions,
 reset values and timing counts. assumes a 50 MHz core clock.
*/
`ifndef MSAG_CFG_SVH
`define MSAG_CFG_SVH

// register offsets
`define MSAG_OFF_CFG 4'h0
`define MSAG_OFF_MUX 4'h1
`define MSAG_OFF_CCR 4'h2
`define MSAG_OFF_HPER 4'h3
`define MSAG_OFF_VCNT 4'h4
`define MSAG_OFF_ENR 4'h5
`define MSAG_OFF_LATCH 4'h6

// field positions
`define MSAG_CFG_HGO 7
`define MSAG_CFG_VGO 6
`define MSAG_MUX_FLYBACK_SELECT 5
`define MSAG_MUX_SRC 4
`define MSAG_MUX_VINV 1
`define MSAG_ENR_FREERUN 0
`define MSAG_LAT_VERT_POL_FLAG 2
`define MSAG_LAT_UP 1
`define MSAG_LAT_DOWN 0

// reset values
`define MSAG_RST_MUX 8'h20
`define MSAG_RST_HPER 8'hFF
`define MSAG_RST_VCNT 8'hFF
`define MSAG_RST_VLSB 3'h7

// timing
`define MSAG_CLK_NS 20
`define MSAG_TICK_NS 250
`define MSAG_HPULSE_NS 2000
`define MSAG_HPULSE_TICKS (`MSAG_HPULSE_NS / `MSAG_TICK_NS)
`define MSAG_VPULSE_LINES 4
`define MSAG_VERT_POL_FLAG_TIME_US 4000
`define MSAG_CNT_MAX 5'h1F
`define MSAG_HLOW_START 8'hFF
`define MSAG_VLINE_START 12'h800

`endif

// file: hdl/msag_pkg.sv
/*
 types of the sync analyzer/generator. mode codes are set here; other numbers come from msag_cfg.svh.
*/
package msag_pkg;
  typedef enum logic [1:0] {
    MSAG_NORM_FALL = 2'h0,
    MSAG_NORM_RISE = 2'h1,
    MSAG_EXT_NEG = 2'h2,
    MSAG_EXT_POS = 2'h3
  } msag_mode_t;

  typedef enum logic [1:0] {
    MSAG_AN_IDLE,
    MSAG_AN_ARMED,
    MSAG_AN_RUN
  } msag_an_state_t;

  typedef struct packed {
    logic [3:0] addr;
    logic [7:0] wdata;
    logic we;
    logic re;
  } msag_bus_req_t;
endpackage : msag_pkg

// file: hdl/msag_top.sv
/*
 sync polarity detector, composite vsync extractor, free-running h/v generator and
 h/v analyzer. registers over a plain strobe port, read data one cycle later.
 assumes all sync and flyback inputs are synchronous to clk_i.
*/
// Contract
// RULE1 - up/down latches follow polarity counter extremes
// RULE2 - vertical polarity flag through integrating filter
// RULE3 - count up high, down low, capture edges
// RULE4 - software clears counter, selects falling normal
// RULE5 - software reads value; 1Fh means negative
// RULE6 - cleared value arms automatic width threshold capture
// RULE7 - software: both latches set means composite
// RULE8 - software sets threshold 00h or 1Fh
// RULE9 - extracted vsync asserts at threshold, negates max
// RULE10 - counter stops at minimum in extraction
// RULE11 - extracted vertical sync always negative polarity; v_sync_out_o inverts it when vinv_q is set
// RULE12 - serrations under 8 us ignored
// RULE13 - extracted vsync feeds first timer capture
// RULE14 - free horizontal period (h+1)/4 us, 2 us
// RULE15 - vertical period h times 11-bit, 4 lines
// RULE16 - software selects free-running generator enable
// RULE17 - generators drive horizontal and vertical outputs
// RULE18 - software keeps analyzer off while free-running
// RULE19 - horizontal analyzer measures low, clears go
// RULE20 - low time (256-result)/4 us, saturates 64
// RULE21 - vertical analyzer counts lines, clears go
// RULE22 - lines equal 2048 minus result, saturating
// RULE23 - software sets positive outputs before analyzing
// RULE24 - mode 00 falling capture, 01 rising capture
// RULE25 - polarity counter saturates at 1Fh
`timescale 1ns/1ns
`include "msag_cfg.svh"

module msag_top #(
  parameter int VERT_POL_FLAG_W = 14
) (
  // clock and reset
  input wire logic clk_i,
  input wire logic resetn_i,
  // register port
  input wire msag_pkg::msag_bus_req_t bus_i,
  output logic [7:0] rdata_o,
  // sync and flyback inputs
  input wire logic h_sync_in_i,
  input wire logic v_sync_in_i,
  input wire logic composite_sync_in_i,
  input wire logic horiz_flyback_in_i,
  input wire logic vert_flyback_in_i,
  // outputs
  output logic h_sync_out_o,
  output logic v_sync_out_o,
  output logic timer_capture_one_o
);
  import msag_pkg::*;

  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!resetn_i);

  logic [7:0] tick_acc_q;
  logic tick;
  logic [4:0] cnt_q, cnt_d, cv_q, thr, floor_v;
  logic arm_q, up_latch_q, down_latch_q, vert_pol_flag_q, ext_q;
  logic [VERT_POL_FLAG_W-1:0] vint_q;
  msag_mode_t mode_q;
  logic extract, mon, cmon, mon_q, mon_rise, mon_fall, cap_ev;
  logic freerun_q, src_sel_q, fb_sel_q, vinv_q;
  logic [7:0] h_period_q, v_count_q, hcnt_q, hmeas_q;
  logic [2:0] vlsb_q;
  logic [10:0] v11, vcnt_q;
  logic [11:0] vmeas_q;
  logic h_gen_q, v_gen_q, h_sync_out_q, v_sync_out_q;
  msag_an_state_t hst_q, vst_q;
  logic hsig, hsig_q, vsig, vsig_q;
  logic wr_cfg, wr_ccr;

  function automatic logic wr_hit(input msag_bus_req_t b, input logic [3:0] off);
    wr_hit = b.we && (b.addr == off);
  endfunction : wr_hit

  assign wr_cfg = wr_hit(bus_i, `MSAG_OFF_CFG);
  assign wr_ccr = wr_hit(bus_i, `MSAG_OFF_CCR);
  assign v11 = {v_count_q, vlsb_q};

  // quarter-microsecond tick, exact on average (12/13 cycle steps)
  assign tick = (9'(tick_acc_q) + 9'(`MSAG_CLK_NS)) >= 9'(`MSAG_TICK_NS);
  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      tick_acc_q <= 8'h00;
    end else if (tick) begin
      tick_acc_q <= 8'(tick_acc_q + 8'(`MSAG_CLK_NS) - 8'(`MSAG_TICK_NS));
    end else begin
      tick_acc_q <= 8'(tick_acc_q + 8'(`MSAG_CLK_NS));
    end
  end

  // control registers written by software
  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      freerun_q <= 1'b0;
      src_sel_q <= 1'b0;
      fb_sel_q <= 1'b1;
      vinv_q <= 1'b0;
    end else begin
      if (wr_hit(bus_i, `MSAG_OFF_ENR)) begin
        freerun_q <= bus_i.wdata[`MSAG_ENR_FREERUN];
      end
      if (wr_hit(bus_i, `MSAG_OFF_MUX)) begin
        fb_sel_q <= bus_i.wdata[`MSAG_MUX_FLYBACK_SELECT];
        src_sel_q <= bus_i.wdata[`MSAG_MUX_SRC];
        vinv_q <= bus_i.wdata[`MSAG_MUX_VINV];
      end
    end
  end

  // polarity counter input; positive composite is inverted for extraction
  assign extract = mode_q[1];
  assign mon = src_sel_q ? composite_sync_in_i : h_sync_in_i;
  assign cmon = (mode_q == MSAG_EXT_POS) ? ~mon : mon;
  assign thr = (mode_q == MSAG_EXT_POS) ? ~cv_q : cv_q;
  assign floor_v = extract ? thr : 5'h00;
  assign mon_rise = mon & ~mon_q;
  assign mon_fall = ~mon & mon_q;
  // RULE24 capture edge select
  assign cap_ev = arm_q && !extract && ((mode_q == MSAG_NORM_RISE) ? mon_rise : mon_fall);

  always_comb begin
    cnt_d = cnt_q;
    if (tick) begin
      // RULE3 RULE25 up/down saturating
      if (cmon && cnt_q != `MSAG_CNT_MAX) begin
        cnt_d = cnt_q + 5'h01;
      // RULE10 floor at minimum
      end else if (!cmon && cnt_q > floor_v) begin
        cnt_d = cnt_q - 5'h01;
      end
    end
  end

  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      cnt_q <= 5'h00;
      mon_q <= 1'b0;
    end else begin
      cnt_q <= cnt_d;
      mon_q <= mon;
    end
  end

  // counter value field, mode and automatic threshold arm
  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      cv_q <= 5'h00;
      mode_q <= MSAG_NORM_FALL;
      arm_q <= 1'b1;
    end else if (wr_ccr) begin
      cv_q <= bus_i.wdata[4:0];
      mode_q <= msag_mode_t'(bus_i.wdata[6:5]);
      // RULE6 cleared value arms width capture
      arm_q <= (bus_i.wdata[4:0] == 5'h00) && !bus_i.wdata[6];
    end else if (cap_ev) begin
      // RULE3 RULE6 capture into threshold
      cv_q <= cnt_q;
    end
  end

  // RULE9 RULE12 extracted vsync; negate one tick past max
  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      ext_q <= 1'b0;
    end else if (!extract) begin
      ext_q <= 1'b0;
    end else if (tick && !cmon && cnt_q != cnt_d && cnt_d == thr) begin
      ext_q <= 1'b1;
    end else if (tick && cmon && cnt_q == `MSAG_CNT_MAX) begin
      ext_q <= 1'b0;
    end
  end

  // RULE1 latches set by counter extremes, write one clears, set wins
  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      up_latch_q <= 1'b0;
      down_latch_q <= 1'b0;
    end else begin
      if (cnt_d == `MSAG_CNT_MAX) begin
        up_latch_q <= 1'b1;
      end else if (wr_hit(bus_i, `MSAG_OFF_LATCH) && bus_i.wdata[`MSAG_LAT_UP]) begin
        up_latch_q <= 1'b0;
      end
      if (cnt_d == 5'h00) begin
        down_latch_q <= 1'b1;
      end else if (wr_hit(bus_i, `MSAG_OFF_LATCH) && bus_i.wdata[`MSAG_LAT_DOWN]) begin
        down_latch_q <= 1'b0;
      end
    end
  end

  // RULE2 integrator, full swing about 4 ms of quarter-us ticks
  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      vint_q <= '1;
      vert_pol_flag_q <= 1'b0;
    end else begin
      if (tick && v_sync_in_i && vint_q != '1) begin
        vint_q <= vint_q + 1'b1;
      end else if (tick && !v_sync_in_i && vint_q != '0) begin
        vint_q <= vint_q - 1'b1;
      end
      if (vint_q == '0) begin
        vert_pol_flag_q <= 1'b1;
      end else if (vint_q == '1) begin
        vert_pol_flag_q <= 1'b0;
      end
    end
  end

  // RULE14 RULE15 free-running generators
  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      hcnt_q <= 8'h00;
      vcnt_q <= 11'h000;
      h_gen_q <= 1'b0;
      v_gen_q <= 1'b0;
    end else if (!freerun_q) begin
      hcnt_q <= 8'h00;
      vcnt_q <= 11'h000;
      h_gen_q <= 1'b0;
      v_gen_q <= 1'b0;
    end else if (tick) begin
      h_gen_q <= hcnt_q < 8'(`MSAG_HPULSE_TICKS);
      v_gen_q <= vcnt_q < 11'(`MSAG_VPULSE_LINES);
      if (hcnt_q >= h_period_q) begin
        hcnt_q <= 8'h00;
        vcnt_q <= (vcnt_q + 11'h001 >= v11) ? 11'h000 : vcnt_q + 11'h001;
      end else begin
        hcnt_q <= hcnt_q + 8'h01;
      end
    end
  end

  // RULE17 outputs from generators; RULE11 extraction negative, inverted at v_sync_out_o when vinv_q is set
  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      h_sync_out_q <= 1'b0;
      v_sync_out_q <= 1'b0;
    end else if (freerun_q) begin
      h_sync_out_q <= h_gen_q;
      v_sync_out_q <= v_gen_q;
    end else begin
      h_sync_out_q <= mon;
      v_sync_out_q <= (extract ? ~ext_q : v_sync_in_i) ^ vinv_q;
    end
  end
  assign h_sync_out_o = h_sync_out_q;
  assign v_sync_out_o = v_sync_out_q;
  // RULE13 extracted vsync into first capture
  assign timer_capture_one_o = extract ? ~ext_q : v_sync_in_i;

  // analyzer signal select
  assign hsig = fb_sel_q ? h_sync_out_q : horiz_flyback_in_i;
  assign vsig = fb_sel_q ? v_sync_out_q : vert_flyback_in_i;
  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      hsig_q <= 1'b0;
      vsig_q <= 1'b0;
    end else begin
      hsig_q <= hsig;
      vsig_q <= vsig;
    end
  end

  // RULE19 RULE20 horizontal low time, result in h period register
  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      hst_q <= MSAG_AN_IDLE;
      hmeas_q <= 8'h00;
      h_period_q <= `MSAG_RST_HPER;
    end else if (wr_cfg && bus_i.wdata[`MSAG_CFG_HGO]) begin
      hst_q <= MSAG_AN_ARMED;
    end else begin
      if (wr_hit(bus_i, `MSAG_OFF_HPER)) begin
        h_period_q <= bus_i.wdata;
      end
      unique case (hst_q)
        MSAG_AN_IDLE: begin
        end
        MSAG_AN_ARMED: begin
          if (hsig_q && !hsig) begin
            hst_q <= MSAG_AN_RUN;
            hmeas_q <= `MSAG_HLOW_START;
          end
        end
        MSAG_AN_RUN: begin
          if (hsig) begin
            h_period_q <= hmeas_q;
            hst_q <= MSAG_AN_IDLE;
          end else if (tick && hmeas_q != 8'h00) begin
            hmeas_q <= hmeas_q - 8'h01;
          end
        end
      endcase
    end
  end

  // RULE21 RULE22 line count during vertical low, result split in two registers
  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      vst_q <= MSAG_AN_IDLE;
      vmeas_q <= 12'h000;
      v_count_q <= `MSAG_RST_VCNT;
      vlsb_q <= `MSAG_RST_VLSB;
    end else if (wr_cfg && bus_i.wdata[`MSAG_CFG_VGO]) begin
      vst_q <= MSAG_AN_ARMED;
      vlsb_q <= bus_i.wdata[2:0];
    end else begin
      if (wr_cfg) begin
        vlsb_q <= bus_i.wdata[2:0];
      end
      if (wr_hit(bus_i, `MSAG_OFF_VCNT)) begin
        v_count_q <= bus_i.wdata;
      end
      unique case (vst_q)
        MSAG_AN_IDLE: begin
        end
        MSAG_AN_ARMED: begin
          if (vsig_q && !vsig) begin
            vst_q <= MSAG_AN_RUN;
            vmeas_q <= `MSAG_VLINE_START;
          end
        end
        MSAG_AN_RUN: begin
          if (vsig) begin
            {v_count_q, vlsb_q} <= vmeas_q[10:0];
            vst_q <= MSAG_AN_IDLE;
          end else if (hsig && !hsig_q && vmeas_q != 12'h000) begin
            vmeas_q <= vmeas_q - 12'h001;
          end
        end
      endcase
    end
  end

  // read data one cycle after the strobe, unmapped reads zero
  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      rdata_o <= 8'h00;
    end else if (bus_i.re) begin
      unique case (bus_i.addr)
        `MSAG_OFF_CFG: rdata_o <= {hst_q != MSAG_AN_IDLE, vst_q != MSAG_AN_IDLE, 3'h0, vlsb_q};
        `MSAG_OFF_MUX: rdata_o <= {2'h0, fb_sel_q, src_sel_q, 2'h0, vinv_q, 1'b0};
        `MSAG_OFF_CCR: rdata_o <= {1'b0, mode_q, cv_q};
        `MSAG_OFF_HPER: rdata_o <= h_period_q;
        `MSAG_OFF_VCNT: rdata_o <= v_count_q;
        `MSAG_OFF_ENR: rdata_o <= {7'h00, freerun_q};
        `MSAG_OFF_LATCH: rdata_o <= {5'h00, vert_pol_flag_q, up_latch_q, down_latch_q};
        default: rdata_o <= 8'h00;
      endcase
    end else begin
      rdata_o <= 8'h00;
    end
  end

  // helper: generated pulse length in ticks
  logic [7:0] hhi_q;
  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      hhi_q <= 8'h00;
    end else if (!h_gen_q) begin
      hhi_q <= 8'h00;
    end else if (tick) begin
      hhi_q <= hhi_q + 8'h01;
    end
  end

  chk_cnt_sat: assert property (tick && cmon && cnt_q == `MSAG_CNT_MAX |=> cnt_q == `MSAG_CNT_MAX) // RULE25
    else $error("polarity counter left its maximum");
  chk_up_latch: assert property (tick && cmon && cnt_q == 5'h1E |=> up_latch_q) // RULE1
    else $error("up latch not set at counter maximum");
  chk_cv_capture: assert property (cap_ev && !wr_ccr |=> cv_q == $past(cnt_q)) // RULE3
    else $error("counter value not captured at edge");
  chk_ext_floor: assert property (extract && !wr_ccr && cnt_q == floor_v && !cmon |=> cnt_q == $past(floor_v)) // RULE10
    else $error("counter went below extraction minimum");
  chk_ext_negate: assert property (extract && tick && cmon && cnt_q == `MSAG_CNT_MAX && !wr_ccr |=> !ext_q) // RULE9
    else $error("extracted sync not negated at maximum");
  chk_ext_out: assert property (extract && !freerun_q && !vinv_q && ext_q |=> !v_sync_out_q) // RULE11
    else $error("extracted sync not negative");
  chk_icap_route: assert property (extract && ext_q |-> !timer_capture_one_o) // RULE13
    else $error("first capture not fed by extracted sync");
  chk_hpulse_len: assert property (freerun_q |-> hhi_q <= 8'(`MSAG_HPULSE_TICKS)) // RULE14
    else $error("generated horizontal pulse too long");
  chk_hlow_done: assert property (hst_q == MSAG_AN_RUN && hsig && !wr_cfg |=> hst_q == MSAG_AN_IDLE
      && h_period_q == $past(hmeas_q)) // RULE19
    else $error("horizontal analyzer did not finish");
  chk_vert_pol_flag_flag: assert property (vint_q == '0 |=> vert_pol_flag_q) // RULE2
    else $error("vertical polarity flag did not follow integrator");
endmodule : msag_top

// file: testbench/msag_sync_src.sv
/*
 sync source model: periodic horizontal pulse train and a vertical level that
 falls and rises in the middle of a horizontal low phase.
 assumes lengths are held stable for at least one line.
*/
`timescale 1ns/1ns
module msag_sync_src (
  // clock and reset
  input wire logic clk_i,
  input wire logic resetn_i,
  // line shape in clocks, frame shape in lines
  input wire logic [15:0] hi_len_i,
  input wire logic [15:0] lo_len_i,
  input wire logic [7:0] lines_i,
  input wire logic [7:0] vlines_i,
  // sync levels
  output logic h_o,
  output logic v_o
);
  logic [16:0] pos_q;
  logic [7:0] line_q;
  logic [16:0] len;
  assign len = 17'(hi_len_i) + 17'(lo_len_i);
  assign h_o = pos_q < 17'(hi_len_i);
  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      pos_q <= '0;
      line_q <= 8'h00;
    end else if (pos_q >= len - 17'h1) begin
      pos_q <= '0;
      line_q <= (line_q + 8'h1 >= lines_i) ? 8'h00 : line_q + 8'h1;
    end else begin
      pos_q <= pos_q + 17'h1;
    end
  end
  // vertical moves mid low so a v low spans exactly vlines rising h edges
  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      v_o <= 1'b1;
    end else if (pos_q == 17'(hi_len_i) + 17'(lo_len_i >> 1)) begin
      v_o <= !(line_q < vlines_i);
    end
  end
endmodule : msag_sync_src

// file: testbench/tb_monitor_sync_analyzer_generator.sv
/*
 self-checking bench of the sync analyzer/generator over its strobe port.
 assumes the sync source model and a 50 MHz clock.
*/
`timescale 1ns/1ns
module tb_monitor_sync_analyzer_generator;
  import msag_pkg::*;
  logic clk_i = 1'b0;
  logic resetn_i = 1'b0;
  msag_bus_req_t bus_i = '0;
  logic [7:0] rdata_o;
  logic cs = 1'b1;
  logic [15:0] hi_len = 16'h0064;
  logic [15:0] lo_len = 16'h03E8;
  logic [7:0] vlines = 8'h00;
  logic h, v, hso, vso, tc1;
  logic [7:0] d;
  int miscompares = 0;
  int tests_run = 0;
  int hi, lo;
  logic [3:0] ra [7] = '{4'h0, 4'h1, 4'h2, 4'h3, 4'h4, 4'h5, 4'h7};
  logic [7:0] rv [7] = '{8'h07, 8'h20, 8'h00, 8'hFF, 8'hFF, 8'h00, 8'h00};

  initial begin
    forever #10 clk_i = ~clk_i;
  end

  msag_sync_src msag_sync_src_inst (.clk_i(clk_i), .resetn_i(resetn_i), .hi_len_i(hi_len),
    .lo_len_i(lo_len), .lines_i(8'h14), .vlines_i(vlines), .h_o(h), .v_o(v));
  msag_top #(.VERT_POL_FLAG_W(4)) msag_top_inst (.clk_i(clk_i), .resetn_i(resetn_i), .bus_i(bus_i),
    .rdata_o(rdata_o), .h_sync_in_i(h), .v_sync_in_i(v), .composite_sync_in_i(cs),
    .horiz_flyback_in_i(h), .vert_flyback_in_i(v), .h_sync_out_o(hso), .v_sync_out_o(vso),
    .timer_capture_one_o(tc1));

  task automatic chk(input logic [11:0] got, input logic [11:0] exp, input string m);
    tests_run++;
    if (got !== exp) begin
      miscompares++;
      $display("unexpected at %0t: %s got %h exp %h", $time, m, got, exp);
    end
  endtask : chk

  task automatic cyc(input int n);
    repeat (n) @(posedge clk_i);
  endtask : cyc

  task automatic wr(input logic [3:0] a, input logic [7:0] w);
    @(posedge clk_i);
    bus_i <= '{addr: a, wdata: w, we: 1'b1, re: 1'b0};
    @(posedge clk_i);
    bus_i.we <= 1'b0;
  endtask : wr

  task automatic rd(input logic [3:0] a, output logic [7:0] r);
    @(posedge clk_i);
    bus_i <= '{addr: a, wdata: 8'h00, we: 1'b0, re: 1'b1};
    @(posedge clk_i);
    bus_i.re <= 1'b0;
    @(negedge clk_i);
    r = rdata_o;
  endtask : rd

  task automatic src(input logic [15:0] hl, input logic [15:0] ll, input logic [7:0] vl);
    @(posedge clk_i);
    hi_len <= hl;
    lo_len <= ll;
    vlines <= vl;
    cyc(3000);
  endtask : src

  task automatic waitgo(input int b);
    int n;
    n = 0;
    d = 8'hFF;
    while (d[b] !== 1'b0 && n < 60) begin
      cyc(500);
      rd(4'h0, d);
      n++;
    end
    chk(12'(d[b]), 12'h0, "go bit");
  endtask : waitgo

  task automatic cs_hold(input logic l, input int n);
    @(posedge clk_i);
    cs <= l;
    cyc(n);
    @(negedge clk_i);
  endtask : cs_hold

  function automatic logic pick(input bit sv);
    return sv ? vso : hso;
  endfunction : pick

  task automatic meas(input bit sv, output int hh, output int ll);
    int n;
    n = 0;
    hh = 0;
    ll = 0;
    @(negedge clk_i);
    while (pick(sv) !== 1'b0 && n < 3000) begin
      @(negedge clk_i);
      n++;
    end
    while (pick(sv) !== 1'b1 && n < 6000) begin
      @(negedge clk_i);
      n++;
    end
    while (pick(sv) === 1'b1 && hh < 3000) begin
      @(negedge clk_i);
      hh++;
    end
    while (pick(sv) === 1'b0 && ll < 3000) begin
      @(negedge clk_i);
      ll++;
    end
  endtask : meas

  task automatic test_done;
    $display("comparisons %0d mismatches %0d", tests_run, miscompares);
    if (miscompares == 0 && tests_run > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask : test_done

  initial begin
    #2000000;
    miscompares++;
    $display("unexpected at %0t: watchdog expired", $time);
    test_done();
  end

  initial begin
    cyc(2);
    resetn_i <= 1'b1;
    for (int i = 0; i < 7; i++) begin
      rd(ra[i], d);
      chk(12'(d), 12'(rv[i]), "reset value");
    end
    wr(4'h7, 8'h5A);
    rd(4'h7, d);
    chk(12'(d), 12'h0, "unmapped read");
    @(negedge clk_i);
    chk(12'(rdata_o), 12'h0, "idle read data");
    $display("test registers done");
    src(16'd1000, 16'd100, 8'd0);
    wr(4'h2, 8'h00);
    wr(4'h6, 8'h03);
    cyc(5000);
    rd(4'h2, d);
    chk(12'(d[4:0]), 12'h1F, "negative count");
    rd(4'h6, d);
    chk(12'(d[2:0]), 12'h2, "negative latches");
    src(16'd100, 16'd1000, 8'd20);
    wr(4'h2, 8'h00);
    wr(4'h6, 8'h03);
    cyc(5000);
    rd(4'h2, d);
    chk(12'(d[4:0] < 5'h1F), 12'h1, "positive count");
    rd(4'h6, d);
    chk(12'(d[2:0]), 12'h5, "positive latches");
    wr(4'h2, 8'h20);
    cyc(5000);
    rd(4'h2, d);
    chk(12'(d), 12'h020, "rising capture");
    wr(4'h2, 8'h05);
    cyc(3000);
    rd(4'h2, d);
    chk(12'(d), 12'h005, "threshold kept");
    $display("test polarity done");
    wr(4'h3, 8'h13);
    wr(4'h4, 8'h00);
    wr(4'h0, 8'h05);
    wr(4'h5, 8'h01);
    meas(1'b0, hi, lo);
    chk(12'(hi), 12'd100, "h pulse");
    chk(12'(lo), 12'd150, "h gap");
    meas(1'b1, hi, lo);
    chk(12'(hi), 12'd1000, "v pulse");
    chk(12'(lo), 12'd250, "v gap");
    wr(4'h5, 8'h00);
    $display("test free run done");
    src(16'd100, 16'd1000, 8'd0);
    for (int f = 0; f < 2; f++) begin
      wr(4'h1, f[0] ? 8'h00 : 8'h20);
      wr(4'h0, 8'h80);
      waitgo(7);
      rd(4'h3, d);
      chk(12'(d >= 8'hAF && d <= 8'hB1), 12'h1, "h low result");
    end
    src(16'd100, 16'd4000, 8'd0);
    wr(4'h0, 8'h80);
    waitgo(7);
    rd(4'h3, d);
    chk(12'(d), 12'h000, "h low saturation");
    src(16'd20, 16'd80, 8'd10);
    for (int f = 0; f < 2; f++) begin
      wr(4'h1, f[0] ? 8'h00 : 8'h20);
      wr(4'h0, 8'h40);
      waitgo(6);
      rd(4'h4, d);
      chk(12'(d), 12'h0FE, "line count high");
      rd(4'h0, d);
      chk(12'(d[2:0]), 12'h6, "line count low");
    end
    $display("test analyzer done");
    src(16'd100, 16'd1000, 8'd0);
    wr(4'h1, 8'h30);
    wr(4'h2, 8'h40);
    for (int i = 0; i < 6; i++) begin
      cs_hold(1'b0, 100);
      cs_hold(1'b1, 1000);
    end
    wr(4'h6, 8'h03);
    chk(12'(tc1), 12'h1, "no extracted pulse");
    cs_hold(1'b0, 600);
    chk(12'(tc1), 12'h0, "extracted start");
    chk(12'(vso), 12'h0, "extracted out low");
    cs_hold(1'b1, 150);
    cs_hold(1'b0, 300);
    chk(12'(tc1), 12'h0, "serration ignored");
    cs_hold(1'b1, 600);
    chk(12'(tc1), 12'h1, "extracted end");
    chk(12'(vso), 12'h1, "extracted out high");
    rd(4'h6, d);
    chk(12'(d[1:0]), 12'h3, "composite latches");
    wr(4'h1, 8'h32);
    cyc(2);
    @(negedge clk_i);
    chk(12'(vso), 12'h0, "inverted vertical out");
    wr(4'h1, 8'h30);
    wr(4'h2, 8'h7F);
    cs_hold(1'b0, 1000);
    chk(12'(tc1), 12'h1, "positive idle");
    cs_hold(1'b1, 600);
    chk(12'(tc1), 12'h0, "positive start");
    chk(12'(vso), 12'h0, "positive out low");
    cs_hold(1'b0, 600);
    chk(12'(tc1), 12'h1, "positive end");
    $display("test extraction done");
    test_done();
  end
endmodule : tb_monitor_sync_analyzer_generator
